// >>> verilog/ddc_pkg.sv
// Purpose: Shared constants and types of the two-channel converter control block.
// Assumes: 32-bit word register port, one clock (20 MHz), 12-bit channel data.
// Notes: Channel 2 fields sit CH_STRIDE bits above the matching channel 1 fields.
package ddc_pkg;
	// Register offsets (byte addresses)
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] SWTRIG_OFF = 8'h04;
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [1:0] SWTRIG_RST = 2'h0;
	// Writable bits of the control register; reserved bits stay zero
	localparam logic [31:0] CTRL_WMASK = 32'h3FFF_3FFF;
	// Field positions within one channel's half of the control register
	localparam int CH_STRIDE = 16;
	localparam int EN_POS = 0;
	localparam int BOFF_POS = 1;
	localparam int TEN_POS = 2;
	localparam int TSEL_LSB = 3;
	localparam int WAVE_LSB = 6;
	localparam int MAMP_LSB = 8;
	localparam int DMAEN_POS = 12;
	localparam int UDRIE_POS = 13;
	// Trigger source codes
	localparam logic [2:0] TSEL_TIM6 = 3'h0;
	localparam logic [2:0] TSEL_RSVD = 3'h1;
	localparam logic [2:0] TSEL_TIM7 = 3'h2;
	localparam logic [2:0] TSEL_TIM9 = 3'h3;
	localparam logic [2:0] TSEL_TIM2 = 3'h4;
	localparam logic [2:0] TSEL_TIM4 = 3'h5;
	localparam logic [2:0] TSEL_EXTI9 = 3'h6;
	localparam logic [2:0] TSEL_SOFT = 3'h7;
	// Number of hardware trigger input lanes
	localparam int TRIG_N = 6;
	// Transfer latencies in clock cycles
	localparam int HW_DELAY_CYC = 3;
	localparam int SW_DELAY_CYC = 1;
	localparam int DIRECT_DELAY_CYC = 1;
	localparam logic [1:0] DELAY_START = 2'(HW_DELAY_CYC - 1);
	// Data width and saturation value
	localparam int DATA_W = 12;
	localparam logic [11:0] DATA_MAX = 12'hFFF;
	localparam logic [3:0] MAMP_SAT = 4'hB;
	localparam logic [11:0] LFSR_SEED = 12'hAAA;
	localparam int FIFO_DEPTH = 8;
	// Holding data word pushed into the block
	typedef struct packed {
		logic [1:0] sel;
		logic [11:0] d2;
		logic [11:0] d1;
	} ddc_hold_t;
	// Per-channel status carried out of the block
	typedef struct packed {
		logic on;
		logic buf_off;
		logic dma_req;
		logic underrun;
		logic irq;
	} ddc_ch_stat_t;
	// Transfer sequencer states
	typedef enum logic [1:0] {
		XF_IDLE = 2'b01,
		XF_DELAY = 2'b10
	} ddc_xf_t;
endpackage : ddc_pkg

// >>> verilog/ddc_top.sv
// Purpose: Control, trigger and holding-to-output transfer of a two-channel converter.
// Assumes: Word-only register port; trigger lanes are asynchronous pins.
// Notes: Holding words pass an 8-word FIFO; it only drains while both channels idle.
// How it works
// - Bits 29/13 enable channel underrun interrupt.
// - Bits 28/12 enable channel DMA requests.
// - Mask code n unmasks n..0, saturates at eleven.
// - Wave field: 00 off, 01 noise, 1x triangle.
// - Wave and source ignored while trigger disabled.
// - Three-bit source picks timer, line or software.
// - Trigger off: holding reaches output next cycle.
// - Hardware trigger: output loads three cycles later.
// - Software trigger transfers in one cycle.
// - Bits 17/1 turn the output buffer off.
// - Bits 16/0 switch the channel on.
// - Writing one requests a software trigger.
// - Trigger bit self-clears one cycle after load.
// - Both registers reset to all zeros.
// - Add masked wave, store sum, then advance.
`timescale 1ns/1ps

module ddc_fifo #(
	parameter int WIDTH = 26,
	parameter int DEPTH = 8
) (
	input wire logic clk_i, // Clock
	input wire logic arst_n_i, // Async reset, active low
	input wire logic [WIDTH-1:0] in_data_i, // Write data
	input wire logic in_valid_i, // Write request
	output logic in_ready_o, // Room available (registered)
	output logic [WIDTH-1:0] out_data_o, // Head word
	output logic out_valid_o, // Head word valid
	input wire logic out_ready_i // Pop head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	logic [AW:0] count_d;
	logic push;
	logic pop;
	// Handshakes and next fill level
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_valid_o = (count_q != '0);
	assign out_data_o = mem_q[rd_ptr_q];
	always_comb begin
		count_d = count_q;
		if (push && !pop) begin
			count_d = count_q + 1'b1;
		end else if (pop && !push) begin
			count_d = count_q - 1'b1;
		end
	end
	// Pointers, level and registered ready
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			in_ready_o <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
			end
			count_q <= count_d;
			in_ready_o <= (count_d != (AW+1)'(DEPTH));
		end
	end
	// Storage array, no reset needed
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_i;
		end
	end
endmodule : ddc_fifo

module ddc_top
	import ddc_pkg::*;
(
	input wire logic clk_i, // 20 MHz clock
	input wire logic arst_n_i, // Async reset, active low
	input wire logic reg_wr_i, // Register word write strobe
	input wire logic reg_rd_i, // Register word read strobe
	input wire logic [7:0] reg_addr_i, // Register byte offset
	input wire logic [31:0] reg_wdata_i, // Register write data
	output logic [31:0] reg_rdata_o, // Read data, valid cycle after read
	input wire ddc_hold_t hold_data_i, // Holding word
	input wire logic hold_valid_i, // Holding word valid
	output logic hold_ready_o, // FIFO accepts a holding word
	input wire logic [TRIG_N-1:0] trig_i, // Trigger pins, async
	input wire logic [1:0] dma_ack_i, // DMA request served, per channel
	input wire logic [1:0] underrun_clr_i, // Clear underrun flag, per channel
	output logic [1:0][11:0] ch_out_o, // Output register per channel
	output ddc_ch_stat_t [1:0] ch_stat_o // Status per channel
);
	logic [31:0] ctrl_q;
	logic [1:0] swtrig_q;
	logic [1:0] sw_clr_q;
	logic [TRIG_N-1:0] sync1_q;
	logic [TRIG_N-1:0] sync2_q;
	logic [TRIG_N-1:0] prev_q;
	logic [TRIG_N-1:0] rise;
	logic [1:0][11:0] hold_q;
	logic [1:0] direct_q;
	logic [1:0] busy;
	ddc_hold_t fifo_data;
	logic fifo_valid;
	logic fifo_pop;

	// Unmask low code+1 bits, saturating at code eleven
	function automatic logic [11:0] ddc_mask(input logic [3:0] code);
		logic [3:0] c;
		c = (code >= MAMP_SAT) ? MAMP_SAT : code;
		return 12'((13'h2 << c) - 13'h1);
	endfunction : ddc_mask

	// Pick the hardware trigger lane for a source code
	function automatic logic ddc_hw_hit(input logic [2:0] tsel, input logic [TRIG_N-1:0] r);
		logic hit;
		hit = 1'b0;
		unique case (tsel)
			TSEL_TIM6: hit = r[0];
			TSEL_TIM7: hit = r[1];
			TSEL_TIM9: hit = r[2];
			TSEL_TIM2: hit = r[3];
			TSEL_TIM4: hit = r[4];
			TSEL_EXTI9: hit = r[5];
			TSEL_RSVD, TSEL_SOFT: hit = 1'b0;
		endcase
		return hit;
	endfunction : ddc_hw_hit

	// Control register, reserved bits forced low
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_q <= CTRL_RST;
		end else if (reg_wr_i && reg_addr_i == CTRL_OFF) begin
			ctrl_q <= reg_wdata_i & CTRL_WMASK;
		end
	end

	// Software trigger bits; a write wins over the self-clear
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			swtrig_q <= SWTRIG_RST;
		end else if (reg_wr_i && reg_addr_i == SWTRIG_OFF) begin
			swtrig_q <= reg_wdata_i[1:0];
		end else begin
			swtrig_q <= swtrig_q & ~sw_clr_q;
		end
	end

	// Read data; trigger register is write-only
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			reg_rdata_o <= (reg_addr_i == CTRL_OFF) ? ctrl_q : '0;
		end
	end

	// Two-stage synchroniser and edge memory for trigger pins
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q <= '0;
		end else begin
			sync1_q <= trig_i;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end
	assign rise = sync2_q & ~prev_q;

	// Holding FIFO drains only while no transfer is in flight
	ddc_fifo #(
		.WIDTH($bits(ddc_hold_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.in_data_i(hold_data_i),
		.in_valid_i(hold_valid_i),
		.in_ready_o(hold_ready_o),
		.out_data_o(fifo_data),
		.out_valid_o(fifo_valid),
		.out_ready_i(busy == 2'b00)
	);
	assign fifo_pop = fifo_valid && (busy == 2'b00);

	// Clock and reset of every assertion below
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		localparam int B = CH_STRIDE * ch;
		logic ten;
		logic [2:0] tsel;
		logic [1:0] wave;
		logic dma_en;
		logic hw_hit;
		logic sw_hit;
		logic start_hw;
		logic xfer;
		logic [11:0] wave_val;
		logic [12:0] sum;
		logic [11:0] lfsr_q;
		logic [11:0] tri_q;
		logic tri_down_q;
		logic [1:0] cnt_q;
		ddc_xf_t state_q;
		logic [11:0] load;

		// Source and wave only count with triggers on
		assign ten = ctrl_q[B + TEN_POS];
		assign tsel = ten ? ctrl_q[B + TSEL_LSB +: 3] : TSEL_RSVD;
		assign wave = ten ? ctrl_q[B + WAVE_LSB +: 2] : 2'b00;
		assign dma_en = ctrl_q[B + DMAEN_POS];
		assign hw_hit = ddc_hw_hit(tsel, rise);
		assign sw_hit = (tsel == TSEL_SOFT) && swtrig_q[ch] && !sw_clr_q[ch];
		assign start_hw = (state_q == XF_IDLE) && hw_hit;
		assign busy[ch] = (state_q != XF_IDLE) || direct_q[ch];
		// Transfer fires after hardware delay or at once for software
		assign xfer = (state_q == XF_DELAY && cnt_q == '0)
			|| (state_q == XF_IDLE && sw_hit);

		// Masked noise, triangle or nothing added to the holding value
		always_comb begin
			wave_val = '0;
			if (wave[1]) begin
				wave_val = tri_q;
			end else if (wave[0]) begin
				wave_val = lfsr_q & ddc_mask(ctrl_q[B + MAMP_LSB +: 4]);
			end
		end
		assign sum = {1'b0, hold_q[ch]} + {1'b0, wave_val};
		assign load = sum[12] ? DATA_MAX : sum[11:0];

		// Transfer sequencer
		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				state_q <= XF_IDLE;
				cnt_q <= '0;
			end else begin
				unique case (state_q)
					XF_IDLE: begin
						if (start_hw) begin
							state_q <= XF_DELAY;
							cnt_q <= DELAY_START;
						end
					end
					XF_DELAY: begin
						if (cnt_q == '0) begin
							state_q <= XF_IDLE;
						end else begin
							cnt_q <= cnt_q - 1'b1;
						end
					end
				endcase
			end
		end

		// Holding value from FIFO, direct path when triggers are off
		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				hold_q[ch] <= '0;
				direct_q[ch] <= 1'b0;
			end else begin
				if (fifo_pop && fifo_data.sel[ch]) begin
					hold_q[ch] <= ch ? fifo_data.d2 : fifo_data.d1;
				end
				direct_q[ch] <= fifo_pop && fifo_data.sel[ch] && !ten;
			end
		end

		// Output register
		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				ch_out_o[ch] <= '0;
			end else if (direct_q[ch]) begin
				ch_out_o[ch] <= hold_q[ch];
			end else if (xfer) begin
				ch_out_o[ch] <= load;
			end
		end

		// Wave counters advance after each loaded sum
		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				lfsr_q <= LFSR_SEED;
				tri_q <= '0;
				tri_down_q <= 1'b0;
			end else if (xfer && wave == 2'b01) begin
				lfsr_q <= {lfsr_q[10:0], lfsr_q[11] ^ lfsr_q[5] ^ lfsr_q[3] ^ lfsr_q[0]};
			end else if (xfer && wave[1]) begin
				if (!tri_down_q && tri_q >= ddc_mask(ctrl_q[B + MAMP_LSB +: 4])) begin
					tri_down_q <= 1'b1;
					tri_q <= tri_q - 1'b1;
				end else if (tri_down_q && tri_q == '0) begin
					tri_down_q <= 1'b0;
					tri_q <= tri_q + 1'b1;
				end else begin
					tri_q <= tri_down_q ? tri_q - 1'b1 : tri_q + 1'b1;
				end
			end
		end

		// Self-clear request one cycle after software load
		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				sw_clr_q[ch] <= 1'b0;
			end else begin
				sw_clr_q[ch] <= xfer && state_q == XF_IDLE;
			end
		end

		// DMA request, underrun flag and interrupt; set wins over clear
		always_ff @(posedge clk_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				ch_stat_o[ch] <= '0;
			end else begin
				ch_stat_o[ch].on <= ctrl_q[B + EN_POS];
				ch_stat_o[ch].buf_off <= ctrl_q[B + BOFF_POS];
				ch_stat_o[ch].dma_req <= (xfer && dma_en)
					|| (ch_stat_o[ch].dma_req && !dma_ack_i[ch]);
				ch_stat_o[ch].underrun <= ((start_hw || sw_hit) && dma_en
					&& ch_stat_o[ch].dma_req)
					|| (ch_stat_o[ch].underrun && !underrun_clr_i[ch]);
				ch_stat_o[ch].irq <= ch_stat_o[ch].underrun
					&& ctrl_q[B + UDRIE_POS];
			end
		end

		sequence s_wait_two;
			!xfer [*2];
		endsequence
		hw_three_cycle_a: assert property (start_hw |-> ##1 s_wait_two ##1 xfer)
			else $error("hardware trigger did not transfer after three cycles");
		sw_one_cycle_a: assert property (sw_hit |=> ch_out_o[ch] == $past(load))
			else $error("software trigger transfer not in one cycle");
		sw_self_clear_a: assert property (sw_hit && !reg_wr_i ##1 !reg_wr_i
			|=> !swtrig_q[ch])
			else $error("software trigger bit not cleared");
		direct_path_a: assert property (fifo_pop && fifo_data.sel[ch] && !ten
			|=> ##1 ch_out_o[ch] == $past(hold_q[ch]))
			else $error("direct transfer latency wrong");
		trig_off_idle_a: assert property (!ten |-> !start_hw && !sw_hit)
			else $error("trigger accepted while triggers disabled");
		reserved_src_a: assert property (tsel == TSEL_RSVD |-> !hw_hit)
			else $error("reserved source produced a trigger");
		dma_req_set_a: assert property (xfer && dma_en |=> ch_stat_o[ch].dma_req)
			else $error("DMA request not raised");
		underrun_irq_a: assert property ((start_hw || sw_hit) && dma_en
			&& ch_stat_o[ch].dma_req && ctrl_q[B + UDRIE_POS]
			|=> ##1 ch_stat_o[ch].irq)
			else $error("underrun did not raise interrupt");
		noise_mask_a: assert property (xfer && wave == 2'b01 && ctrl_q[B + MAMP_LSB +: 4] == 4'h0
			&& hold_q[ch] == '0 |=> ch_out_o[ch] <= 12'h001)
			else $error("noise mask wider than one bit");
	end
endmodule : ddc_top

// >>> verification/ddc_far_model.sv
// Purpose: Far side of the converter block: trigger timers and DMA controller.
// Assumes: One clock; timer pulses are stretched so the pin sync sees them.
// Notes: DMA acks only while ack_en_i is high, so the bench can starve requests.
`timescale 1ns/1ps
module ddc_far_model #(
	parameter int ACK_DLY = 3
) (
	input wire logic clk_i, // Clock
	input wire logic arst_n_i, // Async reset, active low
	input wire logic [5:0] fire_i, // Start a pulse per lane
	input wire logic ack_en_i, // Serve DMA requests
	input wire logic [1:0] dma_req_i, // Requests from the block
	output logic [5:0] trig_o, // Trigger pins
	output logic [1:0] dma_ack_o // Ack pulse per channel
);
	logic [5:0][2:0] len_q;
	logic [1:0][3:0] wait_q;
	// Four-cycle timer pulses
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			len_q <= '0;
		end else begin
			for (int l = 0; l < 6; l++) begin
				if (fire_i[l]) len_q[l] <= 3'h4;
				else if (len_q[l] != 3'h0) len_q[l] <= len_q[l] - 3'h1;
			end
		end
	end
	always_comb begin
		for (int l = 0; l < 6; l++) trig_o[l] = (len_q[l] != 3'h0);
	end
	// Serve a pending request after ACK_DLY waiting cycles
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wait_q <= '0;
			dma_ack_o <= '0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				dma_ack_o[c] <= ack_en_i && dma_req_i[c] && wait_q[c] == 4'(ACK_DLY);
				if (!(ack_en_i && dma_req_i[c]) || wait_q[c] == 4'(ACK_DLY)) wait_q[c] <= '0;
				else wait_q[c] <= wait_q[c] + 4'h1;
			end
		end
	end
endmodule : ddc_far_model

// >>> verification/tb.sv
// Purpose: Self-checking bench of the two-channel converter control block.
// Assumes: Far-side model drives trigger pins and DMA acks.
// Notes: Outputs read at a rising edge show the state after the previous edge.
`timescale 1ns/1ps
module tb;
	import ddc_pkg::*;
	logic clk, arst_n, reg_wr, reg_rd, ack_en, hold_valid, hold_ready;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, v, w;
	ddc_hold_t hold_data;
	logic [5:0] trig, fire;
	logic [1:0] dma_ack, underrun_clr;
	logic [1:0][11:0] ch_out;
	ddc_ch_stat_t [1:0] ch_stat;
	logic [11:0] d, m;
	logic [2:0] t;
	integer seed, bad_count, samples_checked, i, k;
	ddc_top ddc_top_i (.clk_i(clk), .arst_n_i(arst_n), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
		.hold_data_i(hold_data), .hold_valid_i(hold_valid), .hold_ready_o(hold_ready),
		.trig_i(trig), .dma_ack_i(dma_ack), .underrun_clr_i(underrun_clr),
		.ch_out_o(ch_out), .ch_stat_o(ch_stat));
	ddc_far_model ddc_far_model_i (.clk_i(clk), .arst_n_i(arst_n), .fire_i(fire),
		.ack_en_i(ack_en), .dma_req_i({ch_stat[1].dma_req, ch_stat[0].dma_req}),
		.trig_o(trig), .dma_ack_o(dma_ack));
	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic give_up(input int n);
		if (k >= n) begin
			bad_count++;
			report_and_stop;
		end
	endtask : give_up
	task automatic rst;
		arst_n <= 1'b0;
		tick(6);
		arst_n <= 1'b1;
		tick(2);
	endtask : rst
	// Whole-word register access only
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= x;
		tick(1);
		reg_wr <= 1'b0;
		tick(1);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		reg_rd <= 1'b1;
		reg_addr <= a;
		tick(1);
		reg_rd <= 1'b0;
		tick(1);
		v = reg_rdata;
	endtask : rd
	// Leaves valid high so pushes can run back to back
	task automatic push(input logic [11:0] x);
		hold_data <= '{sel: 2'h3, d2: x, d1: x};
		hold_valid <= 1'b1;
		k = 0;
		do begin
			tick(1);
			k++;
		end while (hold_ready !== 1'b1 && k < 20);
		give_up(20);
	endtask : push
	task automatic wait_out(input logic [11:0] x);
		k = 0;
		while (ch_out[0] !== x && k < 16) begin
			tick(1);
			k++;
		end
		give_up(16);
	endtask : wait_out
	// Channel halves: {irq en, dma, mask, wave, source, trig en, buf off, on}
	function automatic logic [31:0] cfg(input logic [13:0] h2, input logic [13:0] h1);
		return {2'h0, h2, 2'h0, h1};
	endfunction : cfg
	function automatic logic [11:0] mask_of(input logic [3:0] n);
		return (n >= 4'hB) ? 12'hFFF : 12'((13'h2 << n) - 13'h1);
	endfunction : mask_of
	// Hang guard
	initial begin
		tick(30000);
		bad_count++;
		report_and_stop;
	end
	// Main sequence
	initial begin
		seed = 32'h3A4E;
		bad_count = 0;
		samples_checked = 0;
		arst_n = 1'b0;
		{reg_wr, reg_rd, hold_valid, ack_en} = 4'h0;
		{reg_addr, reg_wdata, fire, underrun_clr} = '0;
		hold_data = '0;
		rst;
		rd(CTRL_OFF);
		chk(v, 32'h0000_0000);
		rd(SWTRIG_OFF);
		chk(v, 32'h0000_0000);
		chk(32'(ch_stat), 32'h0);
		rd(8'h10);
		chk(v, 32'h0);
		$display("test reset done");
		for (i = 0; i < 8; i++) begin
			w = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
			wr(CTRL_OFF, w);
			rd(CTRL_OFF);
			chk(v, w & 32'h3FFF_3FFF);
			chk(32'({ch_stat[1].on, ch_stat[1].buf_off, ch_stat[0].on, ch_stat[0].buf_off}),
				32'({w[16], w[17], w[0], w[1]}));
		end
		$display("test fields done");
		wr(CTRL_OFF, cfg(14'b00_1111_01_111_0_01, 14'b00_1111_01_111_0_01));
		for (i = 0; i < 9; i++) begin
			d = $random(seed);
			push(d);
		end
		hold_valid <= 1'b0;
		// Five words still queued, popped every other cycle; last one lands at edge ten
		tick(11);
		chk(32'(ch_out), 32'({d, d}));
		m = d;
		d = ~m;
		push(d);
		hold_valid <= 1'b0;
		tick(2);
		chk(32'(ch_out[0]), 32'(m));
		tick(1);
		chk(32'(ch_out), 32'({d, d}));
		$display("test direct load done");
		for (i = 0; i < 7; i++) begin
			t = (i == 6) ? TSEL_RSVD : (i == 0) ? TSEL_TIM6 : 3'(i + 1);
			wr(CTRL_OFF, cfg({6'h0, 2'h0, t, 3'b101}, {6'h0, 2'h0, t, 3'b101}));
			m = ch_out[0];
			d = m ^ 12'($random(seed) | 1);
			push(d);
			hold_valid <= 1'b0;
			tick(4);
			chk(32'(ch_out[0]), 32'(m));
			fire <= (i == 6) ? 6'h3F : ~6'(1 << i);
			tick(1);
			fire <= '0;
			tick(12);
			chk(32'(ch_out[0]), 32'(m));
			if (i < 6) begin
				fire <= 6'(1 << i);
				tick(1);
				fire <= '0;
				wait_out(d);
				chk(32'(ch_out), 32'({d, d}));
			end
		end
		$display("test hardware triggers done");
		wr(CTRL_OFF, cfg(14'b00_0000_00_111_1_01, 14'b00_0000_00_111_1_01));
		for (i = 0; i < 2; i++) begin
			m = ch_out[0];
			d = m ^ 12'h5A5;
			push(d);
			hold_valid <= 1'b0;
			tick(8);
			chk(32'(ch_out[0]), 32'(m));
			wr(SWTRIG_OFF, 32'h0000_0003);
			chk(32'(ch_out[0]), 32'(m));
			tick(1);
			chk(32'(ch_out), 32'({d, d}));
		end
		$display("test software trigger done");
		rst;
		wr(CTRL_OFF, cfg(14'b00_0001_11_111_1_01, 14'b00_0001_10_111_1_01));
		push(12'h100);
		hold_valid <= 1'b0;
		tick(2);
		for (i = 0; i < 5; i++) begin
			wr(SWTRIG_OFF, 32'h0000_0003);
			tick(1);
			d = 12'h100 + 12'((i <= 3) ? i : 6 - i);
			chk(32'(ch_out), 32'({d, d}));
		end
		$display("test triangle done");
		push(12'h000);
		hold_valid <= 1'b0;
		for (i = 0; i < 16; i++) begin
			wr(CTRL_OFF, cfg({2'h0, 4'(i), 8'b01_111_1_01}, {2'h0, 4'(i), 8'b01_111_1_01}));
			wr(SWTRIG_OFF, 32'h0000_0003);
			tick(1);
			chk(32'(ch_out[0] & ~mask_of(4'(i))), 32'h0);
			chk(32'(ch_out[1] & ~mask_of(4'(i))), 32'h0);
		end
		$display("test noise done");
		wr(CTRL_OFF, cfg(14'b01_0000_00_111_1_01, 14'b11_0000_00_111_1_01));
		wr(SWTRIG_OFF, 32'h0000_0003);
		tick(2);
		chk(32'({ch_stat[1].dma_req, ch_stat[0].dma_req}), 32'h3);
		wr(SWTRIG_OFF, 32'h0000_0003);
		tick(3);
		chk(32'({ch_stat[0].underrun, ch_stat[0].irq, ch_stat[1].underrun, ch_stat[1].irq}),
			32'hE);
		underrun_clr <= 2'h3;
		tick(1);
		underrun_clr <= 2'h0;
		tick(3);
		chk(32'({ch_stat[0].underrun, ch_stat[0].irq, ch_stat[1].underrun}), 32'h0);
		ack_en <= 1'b1;
		tick(10);
		chk(32'({ch_stat[1].dma_req, ch_stat[0].dma_req}), 32'h0);
		$display("test dma done");
		report_and_stop;
	end
endmodule : tb
